// [common/tlic_pkg.sv]
// Constants and types shared by the two-level interrupt controller
package tlic_pkg;

  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 21;
  localparam int unsigned PORT_W   = 4;
  localparam int unsigned NSRC     = 4;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned SP_W     = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] A_INTCTL = 3'h0;
  localparam logic [ADDR_W-1:0] A_RSTCTL = 3'h1;
  localparam logic [ADDR_W-1:0] A_PRIO   = 3'h2;
  localparam logic [ADDR_W-1:0] A_PERIPH = 3'h3;
  localparam logic [ADDR_W-1:0] A_PORT_B_A  = 3'h4;
  localparam logic [ADDR_W-1:0] A_STATUS = 3'h5;

  // interrupt_control_main fields
  localparam int unsigned B_GIE  = 7;
  localparam int unsigned B_PERIPHERAL_ENABLE = 6;
  localparam int unsigned B_T0IE = 5;
  localparam int unsigned B_I0IE = 4;
  localparam int unsigned B_PORT_CHANGE_ENABLE = 3;
  localparam int unsigned B_T0IF = 2;
  localparam int unsigned B_I0IF = 1;
  localparam int unsigned B_PORT_CHANGE_FLAG = 0;
  localparam logic [DATA_W-1:0] INTCTL_RST = 8'h00;

  // reset_control_register field
  localparam int unsigned B_PRIORITY_MODE_ENABLE = 7;

  // Source index, also priority register bit
  localparam int unsigned S_RB  = 0;
  localparam int unsigned S_I0  = 1;
  localparam int unsigned S_T0  = 2;
  localparam int unsigned S_PER = 3;
  localparam logic [NSRC-1:0] PRIO_RST = 4'hf;

  // Peripheral source register fields
  localparam int unsigned B_PFLAG = 0;
  localparam int unsigned B_PEN   = 1;

  // Status register fields
  localparam int unsigned B_ST_LOW  = 0;
  localparam int unsigned B_ST_HIGH = 1;

  localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;

  // Timing: one instruction cycle is four core clocks
  localparam int unsigned CLK_NS     = 10;
  localparam int unsigned INSTR_NS   = 40;
  localparam int unsigned INSTR_CLKS = INSTR_NS / CLK_NS;
  localparam logic [1:0]  Q_LAST     = 2'(INSTR_CLKS - 1);
  // Instruction boundaries a request must persist before vectoring
  localparam logic [1:0]  LAT_TICKS  = 2'h2;

  typedef enum logic [1:0] {
    SVC_IDLE,
    SVC_LOW,
    SVC_HIGH,
    SVC_LOW_HIGH
  } tlic_svc_e;

endpackage

// [hdl/tlic_port_change.sv]
// Port-change mismatch detector for the upper port pins
`timescale 1ns/10ps
module tlic_port_change (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic [tlic_pkg::PORT_W-1:0] pins,
  input  wire logic                       capture,
  output logic                            mismatch
);

  logic [tlic_pkg::PORT_W-1:0] latch_ff;
  logic                        mismatch_ff;

  // A port read re-arms the comparison
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_ff <= '0;
    end else if (capture) begin
      latch_ff <= pins;
    end
  end

  // Held while pins differ from last read value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mismatch_ff <= 1'b0;
    end else if (capture) begin
      mismatch_ff <= 1'b0;
    end else begin
      mismatch_ff <= (pins != latch_ff);
    end
  end

  assign mismatch = mismatch_ff;

endmodule

// [hdl/tlic_stack.sv]
// Return address stack used on interrupt entry and return
`timescale 1ns/10ps
module tlic_stack (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     push,
  input  wire logic                     pop,
  input  wire logic [tlic_pkg::PC_W-1:0] din,
  output logic      [tlic_pkg::PC_W-1:0] top
);

  logic [tlic_pkg::PC_W-1:0] mem_ff [tlic_pkg::STK_DEPTH];
  logic [tlic_pkg::SP_W-1:0] sp_ff;

  // Push when full is dropped; pop when empty returns zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_ff <= '0;
    end else if (push && sp_ff != tlic_pkg::SP_W'(tlic_pkg::STK_DEPTH)) begin
      sp_ff <= sp_ff + 4'h1;
    end else if (pop && sp_ff != '0) begin
      sp_ff <= sp_ff - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < int'(tlic_pkg::STK_DEPTH); i++) begin
        mem_ff[i] <= '0;
      end
    end else if (push && sp_ff != tlic_pkg::SP_W'(tlic_pkg::STK_DEPTH)) begin
      mem_ff[sp_ff[2:0]] <= din;
    end
  end

  assign top = (sp_ff == '0) ? '0 : mem_ff[3'(sp_ff - 4'h1)];

endmodule

// [hdl/tlic_top.sv]
// Two-level interrupt controller: registers, arbitration, vectoring
//
// What this block does, and what its software must do (RQ13, RQ17, RQ23)
// RQ1: High priority vectors to 0008h, low priority to 0018h.
// RQ2: In priority mode an enabled high request pre-empts a low routine.
// RQ3: priority_mode_enable is reset control bit 7, cleared at reset.
// RQ4: Priority mode: control bit 7 enables all high priority sources.
// RQ5: Priority mode: control bit 6 enables all low priority sources.
// RQ6: Flag, enable and matching global enable set means vector by priority.
// RQ7: Compatibility mode ignores priorities and always vectors to 0008h.
// RQ8: Compatibility mode: bit 6 gates peripherals, bit 7 gates everything.
// RQ9: Bit 7 clear blocks all; priority mode bit 6 clear blocks low only.
// RQ10: Entry clears the global enable that admitted the interrupt.
// RQ11: No low priority interrupt is taken while high is serviced.
// RQ12: Entry pushes return address and loads the vector address.
// RQ13: Software clears handled flags before re-enabling interrupts.
// RQ14: Return from interrupt sets the enable that entry cleared.
// RQ15: Pin and port-change latency is three to four instruction cycles.
// RQ16: Flags set on their event regardless of any enable.
// RQ17: Software avoids file-to-file moves into control registers when enabled.
// RQ18: Control bits 5, 4, 3 enable timer0, ext_b and port change.
// RQ19: Control bit 2 sets on timer0 overflow and stays until cleared.
// RQ20: Control bit 1 sets on ext_b edge and stays until cleared.
// RQ21: Control bit 0 sets when an upper port pin changes.
// RQ22: Mismatch keeps setting the port-change flag; port read ends it.
// RQ23: Software reads the port before clearing the port-change flag.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module tlic_top (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [tlic_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [tlic_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [tlic_pkg::DATA_W-1:0]   reg_rdata_ff,
  input  wire logic                         timer0_ovf,
  input  wire logic                         ext_b,
  input  wire logic [tlic_pkg::PORT_W-1:0]   port_b_upper_pins,
  input  wire logic                         periph_event,
  input  wire logic [tlic_pkg::PC_W-1:0]     cpu_pc,
  input  wire logic                         cpu_return_from_interrupt_instr,
  output logic                              vec_req_ff,
  output logic      [tlic_pkg::PC_W-1:0]     vec_addr_ff,
  output logic                              ret_req_ff,
  output logic      [tlic_pkg::PC_W-1:0]     ret_addr_ff
);

  logic [tlic_pkg::DATA_W-1:0] intctl_ff;
  logic                        prio_mode_ff;
  logic [tlic_pkg::NSRC-1:0]   prio_ff;
  logic                        per_flag_ff;
  logic                        per_en_ff;
  logic                        ext_prev_ff;
  logic [1:0]                  q_ff;
  logic [1:0]                  lat_ff;
  tlic_pkg::tlic_svc_e         svc_ff;
  logic                        mismatch;
  logic [tlic_pkg::PC_W-1:0]   stack_top;
  logic                        tick;
  logic                        port_rd;
  logic [tlic_pkg::NSRC-1:0]   pend;
  logic                        hi_req;
  logic                        lo_req;
  logic                        any_req;
  logic                        take;
  logic                        take_high;
  logic [tlic_pkg::DATA_W-1:0] nxt_rdata;

  // Write of one field: software value unless hardware sets it
  function automatic logic fld_next(input logic cur, input logic wr, input logic wbit, input logic hw_set);
    fld_next = hw_set | (wr ? wbit : cur);
  endfunction

  function automatic logic wr_at(input logic [tlic_pkg::ADDR_W-1:0] a);
    wr_at = reg_wr && (reg_addr == a);
  endfunction

  assign tick    = (q_ff == tlic_pkg::Q_LAST);
  assign port_rd = reg_rd && (reg_addr == tlic_pkg::A_PORT_B_A);

  tlic_port_change u_pchg (
    .clk      (clk),
    .rstn     (rstn),
    .pins     (port_b_upper_pins),
    .capture  (port_rd),
    .mismatch (mismatch)
  );

  tlic_stack u_stack (
    .clk  (clk),
    .rstn (rstn),
    .push (take),
    .pop  (cpu_return_from_interrupt_instr),
    .din  (cpu_pc),
    .top  (stack_top)
  );

  // Instruction cycle phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= q_ff + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_b;
    end
  end

  // Per-source pending terms (flag and own enable)
  always_comb begin
    pend              = '0;
    pend[tlic_pkg::S_T0]  = intctl_ff[tlic_pkg::B_T0IF] & intctl_ff[tlic_pkg::B_T0IE]; // RQ18
    pend[tlic_pkg::S_I0]  = intctl_ff[tlic_pkg::B_I0IF] & intctl_ff[tlic_pkg::B_I0IE]; // RQ18
    pend[tlic_pkg::S_RB]  = intctl_ff[tlic_pkg::B_PORT_CHANGE_FLAG] & intctl_ff[tlic_pkg::B_PORT_CHANGE_ENABLE]; // RQ18
    pend[tlic_pkg::S_PER] = per_flag_ff & per_en_ff;
  end

  // Request resolution per mode
  always_comb begin
    hi_req = 1'b0;
    lo_req = 1'b0;
    if (prio_mode_ff) begin // RQ3
      hi_req = intctl_ff[tlic_pkg::B_GIE] && |(pend & prio_ff); // RQ4 RQ6
      lo_req = intctl_ff[tlic_pkg::B_GIE] && intctl_ff[tlic_pkg::B_PERIPHERAL_ENABLE] // RQ5 RQ9
               && |(pend & ~prio_ff)
               && (svc_ff == tlic_pkg::SVC_IDLE); // RQ11
    end else begin
      hi_req = intctl_ff[tlic_pkg::B_GIE] // RQ8 RQ9 RQ7
               && (|pend[tlic_pkg::S_T0:tlic_pkg::S_RB]
                   || (pend[tlic_pkg::S_PER] && intctl_ff[tlic_pkg::B_PERIPHERAL_ENABLE]));
    end
    any_req = hi_req | lo_req;
  end

  // Request must hold across boundaries before the vector fires
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lat_ff <= '0;
    end else if (!any_req || take) begin
      lat_ff <= '0;
    end else if (tick && lat_ff != tlic_pkg::LAT_TICKS) begin
      lat_ff <= lat_ff + 2'h1; // RQ15
    end
  end

  // Return takes precedence over a same-cycle entry
  assign take      = tick && any_req && (lat_ff == tlic_pkg::LAT_TICKS) && !cpu_return_from_interrupt_instr; // RQ15 RQ6
  assign take_high = hi_req; // RQ2

  // Service level tracking
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      svc_ff <= tlic_pkg::SVC_IDLE;
    end else begin
      case (svc_ff)
        tlic_pkg::SVC_IDLE: begin
          if (take) begin
            svc_ff <= take_high ? tlic_pkg::SVC_HIGH : tlic_pkg::SVC_LOW;
          end
        end
        tlic_pkg::SVC_LOW: begin
          if (cpu_return_from_interrupt_instr) begin
            svc_ff <= tlic_pkg::SVC_IDLE;
          end else if (take && take_high) begin
            svc_ff <= tlic_pkg::SVC_LOW_HIGH; // RQ2
          end
        end
        tlic_pkg::SVC_HIGH: begin
          if (cpu_return_from_interrupt_instr) begin
            svc_ff <= tlic_pkg::SVC_IDLE;
          end
        end
        default: begin
          if (cpu_return_from_interrupt_instr) begin
            svc_ff <= tlic_pkg::SVC_LOW;
          end
        end
      endcase
    end
  end

  // interrupt_control_main: enables and sticky flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intctl_ff <= tlic_pkg::INTCTL_RST;
    end else begin
      intctl_ff <= wr_at(tlic_pkg::A_INTCTL) ? reg_wdata : intctl_ff;
      // Flags: a hardware set beats a software clear
      intctl_ff[tlic_pkg::B_T0IF] <= fld_next(intctl_ff[tlic_pkg::B_T0IF], wr_at(tlic_pkg::A_INTCTL),
                                              reg_wdata[tlic_pkg::B_T0IF], timer0_ovf); // RQ19 RQ16
      intctl_ff[tlic_pkg::B_I0IF] <= fld_next(intctl_ff[tlic_pkg::B_I0IF], wr_at(tlic_pkg::A_INTCTL),
                                              reg_wdata[tlic_pkg::B_I0IF], ext_b & ~ext_prev_ff); // RQ20 RQ16
      intctl_ff[tlic_pkg::B_PORT_CHANGE_FLAG] <= fld_next(intctl_ff[tlic_pkg::B_PORT_CHANGE_FLAG], wr_at(tlic_pkg::A_INTCTL),
                                              reg_wdata[tlic_pkg::B_PORT_CHANGE_FLAG], mismatch); // RQ21 RQ22
      if (cpu_return_from_interrupt_instr) begin
        // Re-enable what entry cleared
        if (!prio_mode_ff || svc_ff == tlic_pkg::SVC_HIGH || svc_ff == tlic_pkg::SVC_LOW_HIGH) begin
          intctl_ff[tlic_pkg::B_GIE] <= 1'b1; // RQ14
        end else begin
          intctl_ff[tlic_pkg::B_PERIPHERAL_ENABLE] <= 1'b1; // RQ14
        end
      end else if (take) begin
        if (!prio_mode_ff || take_high) begin
          intctl_ff[tlic_pkg::B_GIE] <= 1'b0; // RQ10
        end else begin
          intctl_ff[tlic_pkg::B_PERIPHERAL_ENABLE] <= 1'b0; // RQ10
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prio_mode_ff <= 1'b0; // RQ3
    end else if (wr_at(tlic_pkg::A_RSTCTL)) begin
      prio_mode_ff <= reg_wdata[tlic_pkg::B_PRIORITY_MODE_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prio_ff <= tlic_pkg::PRIO_RST;
    end else if (wr_at(tlic_pkg::A_PRIO)) begin
      prio_ff <= reg_wdata[tlic_pkg::NSRC-1:0];
    end
  end

  // Generic peripheral source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      per_flag_ff <= 1'b0;
      per_en_ff   <= 1'b0;
    end else begin
      per_flag_ff <= fld_next(per_flag_ff, wr_at(tlic_pkg::A_PERIPH),
                              reg_wdata[tlic_pkg::B_PFLAG], periph_event); // RQ16
      if (wr_at(tlic_pkg::A_PERIPH)) begin
        per_en_ff <= reg_wdata[tlic_pkg::B_PEN];
      end
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = '0;
    if (!reg_rd) begin
      nxt_rdata = '0;
    end else if (reg_addr == tlic_pkg::A_INTCTL) begin
      nxt_rdata = intctl_ff;
    end else if (reg_addr == tlic_pkg::A_RSTCTL) begin
      nxt_rdata[tlic_pkg::B_PRIORITY_MODE_ENABLE] = prio_mode_ff;
    end else if (reg_addr == tlic_pkg::A_PRIO) begin
      nxt_rdata[tlic_pkg::NSRC-1:0] = prio_ff;
    end else if (reg_addr == tlic_pkg::A_PERIPH) begin
      nxt_rdata[tlic_pkg::B_PFLAG] = per_flag_ff;
      nxt_rdata[tlic_pkg::B_PEN]   = per_en_ff;
    end else if (reg_addr == tlic_pkg::A_PORT_B_A) begin
      nxt_rdata[tlic_pkg::PORT_W-1:0] = port_b_upper_pins; // RQ22
    end else if (reg_addr == tlic_pkg::A_STATUS) begin
      nxt_rdata[tlic_pkg::B_ST_LOW]  = (svc_ff == tlic_pkg::SVC_LOW) || (svc_ff == tlic_pkg::SVC_LOW_HIGH);
      nxt_rdata[tlic_pkg::B_ST_HIGH] = (svc_ff == tlic_pkg::SVC_HIGH) || (svc_ff == tlic_pkg::SVC_LOW_HIGH);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Vector request to the sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vec_req_ff  <= 1'b0;
      vec_addr_ff <= '0;
    end else begin
      vec_req_ff <= take; // RQ12
      if (take) begin
        vec_addr_ff <= (prio_mode_ff && !take_high) ? tlic_pkg::VEC_LOW : tlic_pkg::VEC_HIGH; // RQ1 RQ7 RQ12
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ret_req_ff  <= 1'b0;
      ret_addr_ff <= '0;
    end else begin
      ret_req_ff <= cpu_return_from_interrupt_instr;
      if (cpu_return_from_interrupt_instr) begin
        ret_addr_ff <= stack_top;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Checks look at what the core sees wherever they can
  compat_vector_a: assert property (vec_req_ff && !$past(prio_mode_ff) |-> vec_addr_ff == tlic_pkg::VEC_HIGH) // RQ7
    else $error("compatibility vector not 0008h");
  low_vector_a: assert property (take && prio_mode_ff && !hi_req // RQ1
    |=> vec_req_ff && vec_addr_ff == tlic_pkg::VEC_LOW)
    else $error("low priority vector not 0018h");
  entry_clear_a: assert property (take && take_high |=> !intctl_ff[tlic_pkg::B_GIE]) // RQ10
    else $error("global enable not cleared on entry");
  low_clear_a: assert property (take && prio_mode_ff && !take_high |=> !intctl_ff[tlic_pkg::B_PERIPHERAL_ENABLE]) // RQ10
    else $error("low enable not cleared on entry");
  no_low_high_a: assert property (svc_ff == tlic_pkg::SVC_HIGH && prio_mode_ff // RQ11
    |=> !(vec_req_ff && vec_addr_ff == tlic_pkg::VEC_LOW))
    else $error("low vector during high service");
  gie_off_a: assert property (!intctl_ff[tlic_pkg::B_GIE] |=> !vec_req_ff) // RQ9
    else $error("vector while all interrupts disabled");
  ext_flag_a: assert property (ext_b && !ext_prev_ff |=> intctl_ff[tlic_pkg::B_I0IF]) // RQ20
    else $error("ext_b edge did not set flag");
  tmr_flag_a: assert property (timer0_ovf |=> intctl_ff[tlic_pkg::B_T0IF]) // RQ19
    else $error("timer0 overflow did not set flag");
  rb_mismatch_a: assert property (mismatch |=> intctl_ff[tlic_pkg::B_PORT_CHANGE_FLAG]) // RQ22
    else $error("mismatch did not hold port-change flag");
  return_from_interrupt_instr_high_a: assert property (cpu_return_from_interrupt_instr && svc_ff == tlic_pkg::SVC_HIGH // RQ14
    |=> intctl_ff[tlic_pkg::B_GIE] ##0 ret_req_ff)
    else $error("return did not restore enable");
  preempt_a: assert property (svc_ff == tlic_pkg::SVC_LOW && take |=> svc_ff == tlic_pkg::SVC_LOW_HIGH) // RQ2
    else $error("high request did not pre-empt low routine");
  // A return at the entry tick defers entry by one more instruction
  latency_a: assert property (any_req && !take && tick && lat_ff == 2'h0 && !cpu_return_from_interrupt_instr // RQ15
    ##1 any_req[*8] |-> ##[0:4] vec_req_ff)
    else $error("vector latency exceeded");

  // Main scenarios the bench is expected to reach
  cover_high_c: cover property (vec_req_ff && vec_addr_ff == tlic_pkg::VEC_HIGH);
  cover_low_c: cover property (vec_req_ff && vec_addr_ff == tlic_pkg::VEC_LOW);
  cover_nest_c: cover property (svc_ff == tlic_pkg::SVC_LOW_HIGH);
  cover_ret_c: cover property (ret_req_ff);
  cover_port_c: cover property (take && intctl_ff[tlic_pkg::B_PORT_CHANGE_FLAG]);

endmodule

// [tb/tlic_cpu_model.sv]
// Core sequencer model: program counter, return stack, return command
`timescale 1ns/10ps
module tlic_cpu_model (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      vec_req,
  input  wire logic [tlic_pkg::PC_W-1:0] vec_addr,
  input  wire logic                      ret_req,
  input  wire logic [tlic_pkg::PC_W-1:0] ret_addr,
  input  wire logic                      ret_cmd,
  output logic      [tlic_pkg::PC_W-1:0] cpu_pc,
  output logic                           cpu_return_from_interrupt_instr
);
  logic [tlic_pkg::PC_W-1:0] pc_d;
  logic [tlic_pkg::PC_W-1:0] stk[$];

  // Bench decides when a routine ends
  assign cpu_return_from_interrupt_instr = ret_cmd;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_pc <= 21'h000100;
      pc_d   <= 21'h000100;
    end else begin
      pc_d <= cpu_pc;
      if (vec_req) begin
        // Design samples the address one cycle before its pulse
        stk.push_back(pc_d);
        cpu_pc <= vec_addr;
      end else if (ret_req) begin
        cpu_pc <= ret_addr;
      end else begin
        cpu_pc <= cpu_pc + 21'h000001;
      end
    end
  end
endmodule

// [tb/tlic_top_test.sv]
// Self-checking bench for the two-level interrupt controller
`timescale 1ns/10ps
module tlic_top_test;
  logic        clk;
  logic        rstn;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  rdata;
  logic        t0;
  logic        extb;
  logic [3:0]  pins;
  logic        pev;
  logic        ret_cmd;
  logic        return_from_interrupt_instr;
  logic [20:0] pc;
  logic        vreq;
  logic [20:0] vaddr;
  logic        rreq;
  logic [20:0] raddr;
  int          n_errors;
  int          comparisons;
  int          n;

  tlic_top dut (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata_ff(rdata), .timer0_ovf(t0), .ext_b(extb), .port_b_upper_pins(pins),
    .periph_event(pev), .cpu_pc(pc), .cpu_return_from_interrupt_instr(return_from_interrupt_instr), .vec_req_ff(vreq),
    .vec_addr_ff(vaddr), .ret_req_ff(rreq), .ret_addr_ff(raddr));

  tlic_cpu_model cpu (.clk(clk), .rstn(rstn), .vec_req(vreq), .vec_addr(vaddr), .ret_req(rreq),
    .ret_addr(raddr), .ret_cmd(ret_cmd), .cpu_pc(pc), .cpu_return_from_interrupt_instr(return_from_interrupt_instr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    // Single-register writes only, never a block move
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(32'(rdata), 32'(e));
  endtask

  // One-cycle event pulse on a source input
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) t0 <= 1'b1;
    else pev <= 1'b1;
    @(posedge clk);
    t0  <= 1'b0;
    pev <= 1'b0;
  endtask

  // Counts edges from the stimulus edge until the vector pulse
  task automatic wait_vec(input logic [20:0] e, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (vreq !== 1'b1 && cnt < 60);
    if (vreq !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: no vector, expected %h", $time, e);
      finish_test();
    end else begin
      chk(32'(vaddr), 32'(e));
    end
  endtask

  task automatic no_vec(input int cycles);
    logic seen;
    seen = 1'b0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      if (vreq !== 1'b0) seen = 1'b1;
    end
    chk(32'(seen), 32'h0);
  endtask

  task automatic ret;
    logic [20:0] e;
    e = cpu.stk.pop_back();
    @(posedge clk);
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    #1;
    chk(32'(rreq), 32'h1);
    chk(32'(raddr), 32'(e));
  endtask

  task automatic t_reset;
    rd(tlic_pkg::A_INTCTL, 8'h00);
    rd(tlic_pkg::A_RSTCTL, 8'h00);
    rd(tlic_pkg::A_PRIO, 8'h0f);
    rd(3'h6, 8'h00);
    $display("reset values test done");
  endtask

  task automatic t_poll;
    pulse(0);
    @(posedge clk);
    extb <= 1'b1;
    no_vec(30);
    rd(tlic_pkg::A_INTCTL, 8'h06);
    wr(tlic_pkg::A_INTCTL, 8'h00);
    rd(tlic_pkg::A_INTCTL, 8'h00);
    @(posedge clk);
    extb <= 1'b0;
    $display("flag polling test done");
  endtask

  task automatic t_compat;
    wr(tlic_pkg::A_PERIPH, 8'h02);
    wr(tlic_pkg::A_INTCTL, 8'h80);
    pulse(1);
    no_vec(30);
    wr(tlic_pkg::A_INTCTL, 8'hc0);
    wait_vec(tlic_pkg::VEC_HIGH, n);
    rd(tlic_pkg::A_INTCTL, 8'h40);
    wr(tlic_pkg::A_PERIPH, 8'h02);
    ret();
    rd(tlic_pkg::A_INTCTL, 8'hc0);
    // All sources low priority, yet compatibility mode ignores that
    wr(tlic_pkg::A_PRIO, 8'h00);
    wr(tlic_pkg::A_INTCTL, 8'ha0);
    pulse(0);
    wait_vec(tlic_pkg::VEC_HIGH, n);
    wr(tlic_pkg::A_INTCTL, 8'h20);
    ret();
    wr(tlic_pkg::A_INTCTL, 8'h00);
    $display("compatibility mode test done");
  endtask

  task automatic t_prio;
    wr(tlic_pkg::A_RSTCTL, 8'h80);
    rd(tlic_pkg::A_RSTCTL, 8'h80);
    wr(tlic_pkg::A_PRIO, 8'h0b);
    wr(tlic_pkg::A_INTCTL, 8'hf0);
    pulse(0);
    wait_vec(tlic_pkg::VEC_LOW, n);
    rd(tlic_pkg::A_INTCTL, 8'hb4);
    @(posedge clk);
    extb <= 1'b1;
    wait_vec(tlic_pkg::VEC_HIGH, n);
    chk(32'(n >= 11 && n <= 14), 32'h1);
    rd(tlic_pkg::A_STATUS, 8'h03);
    rd(tlic_pkg::A_INTCTL, 8'h36);
    wr(tlic_pkg::A_INTCTL, 8'h30);
    ret();
    rd(tlic_pkg::A_INTCTL, 8'hb0);
    rd(tlic_pkg::A_STATUS, 8'h01);
    ret();
    rd(tlic_pkg::A_INTCTL, 8'hf0);
    @(posedge clk);
    extb <= 1'b0;
    // Low enable off: a low source must wait
    wr(tlic_pkg::A_INTCTL, 8'hb0);
    pulse(0);
    no_vec(30);
    wr(tlic_pkg::A_INTCTL, 8'h00);
    wr(tlic_pkg::A_RSTCTL, 8'h00);
    $display("priority mode test done");
  endtask

  task automatic t_port;
    @(posedge clk);
    pins <= 4'h5;
    no_vec(4);
    rd(tlic_pkg::A_INTCTL, 8'h01);
    wr(tlic_pkg::A_INTCTL, 8'h00);
    rd(tlic_pkg::A_INTCTL, 8'h01);
    rd(tlic_pkg::A_PORT_B_A, 8'h05);
    wr(tlic_pkg::A_INTCTL, 8'h00);
    rd(tlic_pkg::A_INTCTL, 8'h00);
    wr(tlic_pkg::A_INTCTL, 8'h88);
    @(posedge clk);
    pins <= 4'ha;
    wait_vec(tlic_pkg::VEC_HIGH, n);
    // One more clock through the mismatch flop
    chk(32'(n >= 12 && n <= 15), 32'h1);
    rd(tlic_pkg::A_INTCTL, 8'h09);
    rd(tlic_pkg::A_PORT_B_A, 8'h0a);
    wr(tlic_pkg::A_INTCTL, 8'h08);
    ret();
    rd(tlic_pkg::A_INTCTL, 8'h88);
    $display("port change test done");
  endtask

  initial begin
    n_errors    = 0;
    comparisons = 0;
    rstn    = 1'b0;
    addr    = 3'h0;
    wdata   = 8'h00;
    wr_s    = 1'b0;
    rd_s    = 1'b0;
    t0      = 1'b0;
    extb    = 1'b0;
    pins    = 4'h0;
    pev     = 1'b0;
    ret_cmd = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_poll();
    t_compat();
    t_prio();
    t_port();
    finish_test();
  end
endmodule
